//--- mpio_far_end.sv
module mpio_far_end (
	// Clock
	input wire logic       clk,
	// Device side
	input wire logic [1:0] line_out,
	input wire logic [1:0] line_oe,
	// Equipment drive
	input wire logic [1:0] ext_en,
	input wire logic [1:0] ext_val,
	// Wire level
	output     logic [1:0] line_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] junk_reg = 2'h0;

	// A floating line wanders, so a stale level never passes for data
	always @(posedge clk)
		junk_reg <= ~junk_reg;

	// Device drive wins; equipment drives only a released line
	assign line_in = (line_oe & line_out) | (~line_oe & ext_en & ext_val)
		| (~line_oe & ~ext_en & junk_reg);
endmodule // mpio_far_end

//--- mpio_line_ctrl.sv
// Functional notes
// R01: digital-input lines become sample bits 14/15
// R02: any digital-input line disables sign extension
// R03: trigger-input lines feed extra trigger sources
// R04: trigger output high while post counter runs
// R05: streaming: trigger output held until stop
// R06: overrange output follows channel zero/one overrange
// R07: running output high while acquisition runs
// R08: armed output high only when armed
// R09: armed output low idle, pretrigger, triggered
// R10: early trigger raised on event, held through post
// R11: checked early trigger needs armed card
// R12: unchecked early trigger ignores arm state
// R13: source spaces events beyond re-arm time
// R14: new mode applied only on start/setup command
// R15: async read in input, trigger, digital modes
// R16: async register bit0 line zero, bit1 line one
// R17: async values driven and read without sampling
// R18: output line reads back driven level
// R19: mode zero is tristate, reset state
// R20: codes one/two are async input/output
// R21: mode register holds exactly one code
// R22: two lines operate independently
module mpio_line_ctrl
	import mpio_pkg::*;
(
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rstn,
	// Register port
	input  wire logic [15:0]         addr,
	input  wire logic [31:0]         wdata,
	input  wire logic                wr_stb,
	input  wire logic                rd_stb,
	output      logic [31:0]         rdata,
	// Acquisition status, same clock
	input  wire logic                acq_running,
	input  wire logic                pretrig_done,
	input  wire logic                card_triggered,
	input  wire logic                post_running,
	input  wire logic                stream_mode,
	input  wire logic                trig_event,
	input  wire logic [1:0]          overrange,
	// Sample stream
	input  wire logic [ADC_W-1:0]    adc_sample,
	input  wire logic                adc_valid,
	output      logic [SAMPLE_W-1:0] sample_word,
	output      logic                sample_valid,
	// Extra trigger sources
	output      logic                extra_trigger_a,
	output      logic                extra_trigger_b,
	// Connector lines
	input  wire logic [1:0]          line_in,
	output      logic [1:0]          line_out,
	output      logic [1:0]          line_oe
);

	// Mode registers, pending and active
	logic [MODE_W-1:0] zero_pend_reg;
	logic [MODE_W-1:0] one_pend_reg;
	logic [MODE_W-1:0] zero_act_reg;
	logic [MODE_W-1:0] one_act_reg;
	logic [1:0]        async_out_reg;
	logic [1:0]        sync1_reg;
	logic [1:0]        sync2_reg;
	logic              post_q_reg;
	logic [1:0]        early_reg;
	logic [1:0]        early_next;
	logic [1:0]        drv_out_next;
	logic [1:0]        drv_oe_next;
	logic [31:0]       rdata_next;
	logic              armed;
	logic              post_done;
	logic              apply_cmd;
	logic              any_sample_in;

	// Only single codes are legal mode values
	function automatic logic valid_mode(input logic [MODE_W-1:0] m);
		case (m)
			MODE_TRISTATE, MODE_ASYNC_INPUT, MODE_ASYNC_OUTPUT,
			MODE_SAMPLE_BIT_INPUT, MODE_TRIGGER_INPUT,
			MODE_TRIGGER_OUTPUT, MODE_OVERRANGE_OUTPUT,
			MODE_RUNNING_OUTPUT, MODE_ARMED_OUTPUT,
			MODE_EARLY_TRIG_OUTPUT, MODE_EARLY_TRIG_UNCHK: valid_mode = 1'b1;
			default: valid_mode = 1'b0;
		endcase
	endfunction

	// Modes where the pin is read, not driven
	function automatic logic input_mode(input logic [MODE_W-1:0] m);
		input_mode = (m == MODE_ASYNC_INPUT) || (m == MODE_TRIGGER_INPUT)
			|| (m == MODE_SAMPLE_BIT_INPUT);
	endfunction

	// Line feeds its level into the sample stream
	function automatic logic sample_in_mode(input logic [MODE_W-1:0] m);
		sample_in_mode = (m == MODE_SAMPLE_BIT_INPUT);
	endfunction

	// Line feeds its level to an extra trigger source
	function automatic logic trig_in_mode(input logic [MODE_W-1:0] m);
		trig_in_mode = (m == MODE_TRIGGER_INPUT);
	endfunction

	// Driven level of one line from its own mode only
	function automatic logic line_level(
		input logic [MODE_W-1:0] m,
		input logic              async_bit,
		input logic              ovr_bit,
		input logic              early_bit
	);
		case (m)
			MODE_ASYNC_OUTPUT:      line_level = async_bit;
			MODE_TRIGGER_OUTPUT:    line_level = post_running
				|| (stream_mode && card_triggered && acq_running); // see R04 see R05
			MODE_OVERRANGE_OUTPUT:  line_level = ovr_bit; // see R06
			MODE_RUNNING_OUTPUT:    line_level = acq_running; // see R07
			MODE_ARMED_OUTPUT:      line_level = armed; // see R08
			MODE_EARLY_TRIG_OUTPUT: line_level = early_bit; // see R10
			MODE_EARLY_TRIG_UNCHK:  line_level = early_bit; // see R12
			default:                line_level = 1'b0;
		endcase
	endfunction

	// Pin drives only in output modes
	function automatic logic line_drives(input logic [MODE_W-1:0] m);
		line_drives = (m != MODE_TRISTATE) && !input_mode(m); // see R19 see R20
	endfunction

	// Early trigger event qualification per mode
	function automatic logic early_set(input logic [MODE_W-1:0] m);
		case (m)
			MODE_EARLY_TRIG_OUTPUT: early_set = trig_event && armed; // see R11
			MODE_EARLY_TRIG_UNCHK:  early_set = trig_event; // see R12
			default:                early_set = 1'b0;
		endcase
	endfunction

	// Armed only between pretrigger fill and trigger
	assign armed = acq_running && pretrig_done && !card_triggered; // see R08 see R09

	// Post counter end seen as falling edge of its run flag
	assign post_done = post_q_reg && !post_running;

	// Start and setup commands both latch the pending modes
	assign apply_cmd = wr_stb && (addr == ADDR_COMMAND)
		&& (wdata[CMD_CARD_START_BIT] || wdata[CMD_APPLY_SETUP_BIT]);

	// Any digital-input line takes over both upper sample bits
	assign any_sample_in = sample_in_mode(zero_act_reg)
		|| sample_in_mode(one_act_reg);

	// Two-stage synchroniser on the connector pins
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			sync1_reg <= 2'h0;
			sync2_reg <= 2'h0;
		end
		else
		begin
			sync1_reg <= line_in;
			sync2_reg <= sync1_reg;
		end
	end

	// Pending modes; illegal mixtures are dropped so one code stays held
	// Upper write bits are ignored; the mode field is the low bits only
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			zero_pend_reg <= MODE_RESET;
			one_pend_reg  <= MODE_RESET;
		end
		else if (wr_stb)
		begin
			if (addr == ADDR_LINE_ZERO_MODE && valid_mode(wdata[MODE_W-1:0]))
				zero_pend_reg <= wdata[MODE_W-1:0]; // see R21
			if (addr == ADDR_LINE_ONE_MODE && valid_mode(wdata[MODE_W-1:0]))
				one_pend_reg <= wdata[MODE_W-1:0]; // see R21
		end
	end

	// Active modes change only on a command, so a mode write alone
	// never switches a line under a running acquisition
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			zero_act_reg <= MODE_RESET; // see R19
			one_act_reg  <= MODE_RESET;
		end
		else if (apply_cmd)
		begin
			zero_act_reg <= zero_pend_reg; // see R14
			one_act_reg  <= one_pend_reg;
		end
	end

	// Asynchronous output value, bit per line
	always_ff @(posedge clk)
	begin
		if (!rstn)
			async_out_reg <= ASYNC_OUT_RESET;
		else if (wr_stb && addr == ADDR_ASYNC_LINE_IO)
			async_out_reg <= wdata[1:0]; // see R16 see R17
	end

	// Early trigger flags: event sets, post counter end clears, set wins
	// Stopping the card clears too, so a cut run leaves no flag behind
	always_comb
	begin
		early_next = early_reg;
		if (post_done)
			early_next = 2'h0;
		if (!acq_running && !post_running)
			early_next = 2'h0;
		if (early_set(zero_act_reg))
			early_next[0] = 1'b1; // see R10
		if (early_set(one_act_reg))
			early_next[1] = 1'b1; // see R22
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			early_reg  <= 2'h0;
			post_q_reg <= 1'b0;
		end
		else
		begin
			early_reg  <= early_next;
			post_q_reg <= post_running;
		end
	end

	// Per-line drive, each from its own mode
	always_comb
	begin
		drv_out_next[0] = line_level(zero_act_reg, async_out_reg[0],
			overrange[0], early_reg[0]);
		drv_out_next[1] = line_level(one_act_reg, async_out_reg[1],
			overrange[1], early_reg[1]); // see R22
		drv_oe_next[0]  = line_drives(zero_act_reg);
		drv_oe_next[1]  = line_drives(one_act_reg);
	end

	// Registered pin drive; one cycle behind the status inputs, two behind trig_event in early trigger modes
	// Level is masked by the enable so a released pin never carries data
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			line_out <= 2'h0;
			line_oe  <= 2'h0;
		end
		else
		begin
			line_out <= drv_out_next & drv_oe_next;
			line_oe  <= drv_oe_next;
		end
	end

	// Extra trigger sources; masks elsewhere decide if they fire
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			extra_trigger_a <= 1'b0;
			extra_trigger_b <= 1'b0;
		end
		else
		begin
			extra_trigger_a <= trig_in_mode(zero_act_reg) && sync2_reg[0]; // see R03
			extra_trigger_b <= trig_in_mode(one_act_reg) && sync2_reg[1]; // see R03
		end
	end

	// Sample word: upper bits carry lines or the sign
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			sample_word  <= '0;
			sample_valid <= 1'b0;
		end
		else
		begin
			sample_valid <= adc_valid;
			if (adc_valid)
			begin
				sample_word[ADC_W-1:0] <= adc_sample;
				if (!any_sample_in)
				begin
					sample_word[SAMPLE_BIT_ZERO] <= adc_sample[ADC_W-1];
					sample_word[SAMPLE_BIT_ONE]  <= adc_sample[ADC_W-1];
				end
				else
				begin
					// Sign extension off once any line is digital input
					sample_word[SAMPLE_BIT_ZERO] <= sample_in_mode(zero_act_reg)
						&& sync2_reg[0]; // see R01 see R02
					sample_word[SAMPLE_BIT_ONE]  <= sample_in_mode(one_act_reg)
						&& sync2_reg[1]; // see R01 see R02
				end
			end
		end
	end

	// Read mux; async bits show pin in input modes, drive level otherwise
	always_comb
	begin
		rdata_next = RDATA_RESET;
		case (addr)
			ADDR_LINE_ZERO_MODE: rdata_next[MODE_W-1:0] = zero_pend_reg;
			ADDR_LINE_ONE_MODE:  rdata_next[MODE_W-1:0] = one_pend_reg;
			ADDR_ACTIVE_MODE:
			begin
				rdata_next[ACTIVE_ZERO_LSB +: MODE_W] = zero_act_reg;
				rdata_next[ACTIVE_ONE_LSB +: MODE_W]  = one_act_reg;
			end
			ADDR_ASYNC_LINE_IO:
			begin
				rdata_next[0] = input_mode(zero_act_reg) ? sync2_reg[0] : line_out[0]; // see R15 see R18
				rdata_next[1] = input_mode(one_act_reg) ? sync2_reg[1] : line_out[1]; // see R16
			end
			// Command register is write only and reads as zero
			default: rdata_next = RDATA_RESET;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (!rstn)
			rdata <= RDATA_RESET;
		else if (rd_stb)
			rdata <= rdata_next;
		else
			rdata <= RDATA_RESET;
	end

endmodule // mpio_line_ctrl

//--- mpio_line_ctrl_tb_top.sv
module mpio_line_ctrl_tb_top
	import mpio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// Bench drive; st is stream, post, triggered, pretrig, running
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [15:0] addr = 16'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr_stb = 1'b0;
	logic        rd_stb = 1'b0;
	logic [4:0]  st = 5'h0;
	logic        trig_event = 1'b0;
	logic [1:0]  ovr = 2'h0;
	logic [1:0]  ext_en = 2'h0;
	logic [1:0]  ext_val = 2'h0;
	logic        adc_valid = 1'b1;
	logic [13:0] adc_s = 14'h2000;
	// Observed
	logic [31:0] rdata;
	logic [15:0] sample_word;
	logic        sample_valid, extra_a, extra_b;
	logic [1:0]  line_in, line_out, line_oe;
	int          fails = 0;
	int          compares = 0;

	mpio_line_ctrl dut (
		.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .acq_running(st[0]), .pretrig_done(st[1]),
		.card_triggered(st[2]), .post_running(st[3]), .stream_mode(st[4]),
		.trig_event(trig_event), .overrange(ovr), .adc_sample(adc_s),
		.adc_valid(adc_valid), .sample_word(sample_word), .sample_valid(sample_valid),
		.extra_trigger_a(extra_a), .extra_trigger_b(extra_b), .line_in(line_in),
		.line_out(line_out), .line_oe(line_oe)
	);
	mpio_far_end u_far (
		.clk(clk), .line_out(line_out), .line_oe(line_oe), .ext_en(ext_en),
		.ext_val(ext_val), .line_in(line_in)
	);

	// 50 MHz clock
	always #10 clk = ~clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One edge passes before the next strobe may rise
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		wr_stb <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_stb <= 1'b0;
		@(posedge clk);
	endtask

	// Data stand only in the slot after the strobe
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask

	task automatic set_modes(input logic [11:0] m0, input logic [11:0] m1);
		wr(ADDR_LINE_ZERO_MODE, {20'h0, m0});
		wr(ADDR_LINE_ONE_MODE, {20'h0, m1});
		wr(ADDR_COMMAND, 32'h2);
		repeat (3) @(posedge clk);
	endtask

	// Compare off the edge, then realign to it
	task automatic lines_are(input logic [4:0] s, input logic [1:0] e);
		st <= s;
		repeat (3) @(posedge clk);
		#1 chk(32'(line_out), 32'(e));
		@(posedge clk);
	endtask

	// Events are spaced far beyond the re-arm time
	task automatic pulse_trig;
		trig_event <= 1'b1;
		@(posedge clk);
		trig_event <= 1'b0;
	endtask

	task automatic t_reset;
		logic [31:0] v;
		repeat (2) @(posedge clk);
		#1 chk(32'(line_oe), 32'h0);
		chk(32'(sample_word), 32'he000);
		@(posedge clk);
		rd(ADDR_ASYNC_LINE_IO, v);
		chk(v, 32'h0);
		rd(16'hb810, v);
		chk(v, 32'h0);
		adc_s <= 14'h1234;
		repeat (2) @(posedge clk);
		#1 chk(32'(sample_word), 32'h1234);
		@(posedge clk);
		adc_valid <= 1'b0;
		adc_s <= 14'h2000;
		repeat (2) @(posedge clk);
		#1 chk(32'(sample_valid), 32'h0);
		chk(32'(sample_word), 32'h1234);
		@(posedge clk);
		adc_valid <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk(32'(sample_word), 32'he000);
		chk(32'(sample_valid), 32'h1);
		@(posedge clk);
	endtask

	task automatic t_async;
		logic [31:0] v;
		ext_en <= 2'h1;
		ext_val <= 2'h1;
		wr(ADDR_LINE_ONE_MODE, {20'h0, MODE_ASYNC_OUTPUT});
		wr(ADDR_ASYNC_LINE_IO, 32'h2);
		repeat (3) @(posedge clk);
		#1 chk(32'(line_oe), 32'h0);
		@(posedge clk);
		set_modes(MODE_ASYNC_INPUT, MODE_ASYNC_OUTPUT);
		#1 chk(32'(line_oe), 32'h2);
		chk(32'(line_out), 32'h2);
		@(posedge clk);
		rd(ADDR_ASYNC_LINE_IO, v);
		chk(v & 32'h3, 32'h3);
		wr(ADDR_ASYNC_LINE_IO, 32'h0);
		ext_val <= 2'h0;
		repeat (4) @(posedge clk);
		rd(ADDR_ASYNC_LINE_IO, v);
		chk(v & 32'h3, 32'h0);
	endtask

	task automatic t_status;
		set_modes(MODE_TRIGGER_OUTPUT, MODE_RUNNING_OUTPUT);
		lines_are(5'h01, 2'h2);
		lines_are(5'h09, 2'h3);
		lines_are(5'h05, 2'h2);
		lines_are(5'h15, 2'h3);
		lines_are(5'h14, 2'h0);
		set_modes(MODE_OVERRANGE_OUTPUT, MODE_OVERRANGE_OUTPUT);
		ovr <= 2'h1;
		lines_are(5'h00, 2'h1);
		ovr <= 2'h2;
		lines_are(5'h00, 2'h2);
		set_modes(MODE_ARMED_OUTPUT, MODE_TRISTATE);
		lines_are(5'h01, 2'h0);
		lines_are(5'h03, 2'h1);
		lines_are(5'h07, 2'h0);
		lines_are(5'h00, 2'h0);
	endtask

	task automatic t_early;
		set_modes(MODE_EARLY_TRIG_OUTPUT, MODE_EARLY_TRIG_UNCHK);
		st <= 5'h01;
		pulse_trig;
		lines_are(5'h01, 2'h2);
		lines_are(5'h00, 2'h0);
		st <= 5'h03;
		pulse_trig;
		lines_are(5'h0f, 2'h3);
		lines_are(5'h05, 2'h0);
	endtask

	task automatic t_digital;
		logic [31:0] v;
		set_modes(MODE_SAMPLE_BIT_INPUT, MODE_TRIGGER_INPUT);
		ext_en <= 2'h3;
		ext_val <= 2'h1;
		repeat (5) @(posedge clk);
		#1 chk(32'(sample_word), 32'h6000);
		chk(32'({extra_a, extra_b}), 32'h0);
		@(posedge clk);
		ext_val <= 2'h2;
		repeat (5) @(posedge clk);
		#1 chk(32'(sample_word), 32'h2000);
		chk(32'({extra_a, extra_b}), 32'h1);
		@(posedge clk);
		rd(ADDR_ASYNC_LINE_IO, v);
		chk(v & 32'h3, 32'h2);
		wr(ADDR_LINE_ZERO_MODE, 32'h3);
		wr(ADDR_COMMAND, 32'h1);
		rd(ADDR_LINE_ZERO_MODE, v);
		chk(v & 32'hfff, 32'(MODE_SAMPLE_BIT_INPUT));
		rd(ADDR_ACTIVE_MODE, v);
		chk(v, 32'h0010_0004);
	endtask

	task automatic finish_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_async;
		t_status;
		t_early;
		t_digital;
		finish_test;
	end

	// Watchdog well beyond the fewer than two hundred cycles needed
	initial
	begin
		repeat (5000) @(posedge clk);
		fails++;
		finish_test;
	end
endmodule // mpio_line_ctrl_tb_top

//--- mpio_pkg.sv
package mpio_pkg;

	// Register byte addresses
	localparam logic [15:0] ADDR_LINE_ZERO_MODE = 16'hb800;
	localparam logic [15:0] ADDR_LINE_ONE_MODE  = 16'hb804;
	localparam logic [15:0] ADDR_COMMAND        = 16'hb808;
	localparam logic [15:0] ADDR_ACTIVE_MODE    = 16'hb80c;
	localparam logic [15:0] ADDR_ASYNC_LINE_IO  = 16'hb874;

	// Mode codes, one bit each except tristate, which is zero
	localparam int MODE_W = 12;
	localparam logic [11:0] MODE_TRISTATE          = 12'h000;
	localparam logic [11:0] MODE_ASYNC_INPUT       = 12'h001;
	localparam logic [11:0] MODE_ASYNC_OUTPUT      = 12'h002;
	localparam logic [11:0] MODE_SAMPLE_BIT_INPUT  = 12'h004;
	localparam logic [11:0] MODE_TRIGGER_INPUT     = 12'h010;
	localparam logic [11:0] MODE_TRIGGER_OUTPUT    = 12'h020;
	localparam logic [11:0] MODE_OVERRANGE_OUTPUT  = 12'h040;
	localparam logic [11:0] MODE_RUNNING_OUTPUT    = 12'h100;
	localparam logic [11:0] MODE_ARMED_OUTPUT      = 12'h200;
	localparam logic [11:0] MODE_EARLY_TRIG_OUTPUT = 12'h400;
	localparam logic [11:0] MODE_EARLY_TRIG_UNCHK  = 12'h800;
	localparam logic [11:0] MODE_RESET             = 12'h000;

	// Command register bit positions
	localparam int CMD_CARD_START_BIT  = 0;
	localparam int CMD_APPLY_SETUP_BIT = 1;

	// Active mode readback field positions
	localparam int ACTIVE_ZERO_LSB = 0;
	localparam int ACTIVE_ONE_LSB  = 16;

	// Sample word layout
	localparam int ADC_W          = 14;
	localparam int SAMPLE_W       = 16;
	localparam int SAMPLE_BIT_ONE = 15;
	localparam int SAMPLE_BIT_ZERO = 14;

	// Values after reset
	localparam logic [1:0]  ASYNC_OUT_RESET = 2'h0;
	localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

endpackage : mpio_pkg

//--- mpio_props.sv
module mpio_props
	import mpio_pkg::*;
(
	// Clock and reset
	input wire logic                clk,
	input wire logic                rstn,
	// Register port
	input wire logic [15:0]         addr,
	input wire logic [31:0]         wdata,
	input wire logic                wr_stb,
	input wire logic                rd_stb,
	input wire logic [31:0]         rdata,
	// Sample stream
	input wire logic [ADC_W-1:0]    adc_sample,
	input wire logic                adc_valid,
	input wire logic [SAMPLE_W-1:0] sample_word,
	input wire logic                sample_valid,
	// Triggers and lines
	input wire logic                extra_trigger_a,
	input wire logic                extra_trigger_b,
	input wire logic [1:0]          line_in,
	input wire logic [1:0]          line_out,
	input wire logic [1:0]          line_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// Command write that may change the applied modes
	wire apply_w = wr_stb && addr == ADDR_COMMAND && wdata[1:0] != 2'h0;

	// Read of the direct line register
	sequence rd_io_s;
		rd_stb && addr == ADDR_ASYNC_LINE_IO;
	endsequence

	oe_reset_a: assert property (disable iff (1'b0) !rstn |=> line_oe == 2'h0)
		else $error("line drive not released by reset");
	oe_cmd_a: assert property ($changed(line_oe) && $past(rstn) |-> $past(apply_w, 2))
		else $error("line drive changed without a command");
	out_gated_a: assert property ((line_out & ~line_oe) == 2'h0)
		else $error("level shown on an undriven line");
	trig_a_pin_a: assert property (extra_trigger_a |-> $past(line_in[0], 3))
		else $error("trigger a without line zero high");
	trig_b_pin_a: assert property (extra_trigger_b |-> $past(line_in[1], 3))
		else $error("trigger b without line one high");
	word_pipe_a: assert property (adc_valid |=> sample_word[ADC_W-1:0] == $past(adc_sample))
		else $error("sample low bits lost");
	valid_pipe_a: assert property (1'b1 |=> sample_valid == $past(adc_valid))
		else $error("sample valid out of step");
	rdata_idle_a: assert property (!rd_stb |=> rdata == 32'h0)
		else $error("read data outside read slot");
	readback_a: assert property (rd_io_s ##0 line_oe[1] |=> rdata[1] == $past(line_out[1]))
		else $error("readback differs from driven level");
endmodule // mpio_props

bind mpio_line_ctrl mpio_props u_props (.*);
